/* sfe_pkg.sv */
// Package with constants and carrier types for the serial flash front end.
package sfe_pkg;
    localparam int OP_W = 8;
    localparam int ADDR_BYTES = 3;
    localparam logic [8:0] PAGE_BYTES_STD = 9'h100;
    localparam logic [8:0] PAGE_BYTES_ALT = 9'h108;
    localparam logic [3:0] SECTOR_CNT = 4'h8;
    localparam int BUSY_TIME_US = 20;
    localparam int CLK_MHZ = 100;
    localparam int BUSY_CYCLES = BUSY_TIME_US * CLK_MHZ;
    localparam logic [1:0] POR_CYCLES = 2'h3;
    localparam logic [7:0] PROT_MAP_RESET = 8'h00;
    localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h82;
    localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
    localparam logic [7:0] OPC_BLOCK_ERASE = 8'h50;
    localparam logic [7:0] OPC_SECTOR_ERASE = 8'h7C;
    localparam logic [7:0] OPC_PROT_WRITE = 8'h3F;
    localparam logic [7:0] OPC_PROT_ARM = 8'h3D;
    localparam logic [7:0] OPC_STATUS_READ = 8'hD7;
    localparam logic [7:0] OPC_PAGE_SIZE = 8'h3A;

    typedef struct packed {
        logic sel_n;
        logic sck;
        logic sdi;
    } sfe_pins_t;

    typedef struct packed {
        logic       rise;
        logic       fall;
        logic       frame_start;
        logic       frame_end;
        logic       selected;
        logic       sdi;
    } sfe_evt_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD = 4'b0010,
        ST_DROP = 4'b0100,
        ST_BUSY = 4'b1000
    } sfe_state_t;
endpackage

/* sfe_sync.sv */
// Two-stage synchronisers and edge detection for the serial pins.
`timescale 1ns/100ps
module sfe_sync (
    input wire logic CLK,
    input wire logic NRST,
    input wire sfe_pkg::sfe_pins_t pins,
    output sfe_pkg::sfe_evt_t evt
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [2:0] prev_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            meta_q <= 3'h7;
            sync_q <= 3'h7;
            prev_q <= 3'h7;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Bit 2 is select, bit 1 the serial clock, bit 0 the serial input.
    assign evt.rise = sync_q[1] & ~prev_q[1] & ~sync_q[2];
    assign evt.fall = ~sync_q[1] & prev_q[1] & ~sync_q[2];
    assign evt.frame_start = ~sync_q[2] & prev_q[2];
    assign evt.frame_end = sync_q[2] & ~prev_q[2];
    assign evt.selected = ~sync_q[2];
    assign evt.sdi = sync_q[0];
endmodule

/* sfe_timer.sv */
// Internal program and erase timer that runs without host strobes.
`timescale 1ns/100ps
module sfe_timer #(
    parameter int BUSY_CYCLES = sfe_pkg::BUSY_CYCLES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic start,
    output logic busy
);
    logic [15:0] cnt_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= 16'h0000;
        end else if (start) begin
            cnt_q <= 16'(BUSY_CYCLES);
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    assign busy = (cnt_q != 16'h0000);
endmodule

/* sfe_front_end.sv */
// Pin-level serial front end: framing, shifting, write guard and reset.
`timescale 1ns/100ps
module sfe_front_end #(
    parameter int BUSY_CYCLES = sfe_pkg::BUSY_CYCLES
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SEL_N,
    input wire logic SCK,
    input wire logic SDI,
    input wire logic WGUARD_N,
    input wire logic [7:0] STATUS_IN,
    output logic SDO,
    output logic SDO_OE,
    output logic STANDBY,
    output logic BUSY,
    output logic PAGE_ALT,
    output logic [7:0] OPCODE,
    output logic [23:0] ADDRESS,
    output logic CMD_VALID,
    output logic [7:0] PROT_MAP
);
    sfe_pkg::sfe_evt_t evt;
    sfe_pkg::sfe_pins_t pins;
    sfe_pkg::sfe_state_t state_q, state_d;
    logic [1:0] por_q;
    logic por_done;
    logic [31:0] shreg_q;
    logic [5:0] bitcnt_q;
    logic [7:0] prot_q;
    logic armed_q;
    logic page_alt_q;
    logic [7:0] out_q;
    logic sdo_q, oe_q, standby_q, cmd_valid_q;
    logic [7:0] opcode_q;
    logic [23:0] addr_q;
    logic busy;
    logic tmr_start;
    logic op_done, addr_done;
    logic [7:0] op_now;
    logic is_write, is_prot, guarded, shift_in;
    logic [3:0] sector_idx;
    logic [23:0] addr_now;
    logic busy_q;
    logic [1:0] wg_q;
    logic guard_on;

    function automatic logic writes_array(input logic [7:0] op);
        writes_array = (op == sfe_pkg::OPC_PAGE_PROGRAM) || (op == sfe_pkg::OPC_PAGE_ERASE) ||
            (op == sfe_pkg::OPC_BLOCK_ERASE) || (op == sfe_pkg::OPC_SECTOR_ERASE);
    endfunction

    assign pins = '{sel_n: SEL_N, sck: SCK, sdi: SDI};

    sfe_sync u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .pins(pins),
        .evt(evt)
    );

    sfe_timer #(.BUSY_CYCLES(BUSY_CYCLES)) u_timer (
        .CLK(CLK),
        .NRST(NRST),
        .start(tmr_start),
        .busy(busy)
    );

    // Power-on settle counter: it starts cleared under async reset and counts up with no pin help.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            por_q <= 2'h0;
        end else if (por_q != sfe_pkg::POR_CYCLES) begin
            por_q <= por_q + 2'h1;
        end
    end
    assign por_done = (por_q == sfe_pkg::POR_CYCLES);

    // The guard pin is asynchronous, so it passes two flops before any decision reads it.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wg_q <= 2'h3;
        end else begin
            wg_q <= {wg_q[0], WGUARD_N};
        end
    end
    assign guard_on = !wg_q[1];

    // Shifting happens only while selected and after a fresh frame start.
    assign shift_in = evt.rise && evt.selected && (state_q == sfe_pkg::ST_CMD);
    assign op_now = {shreg_q[6:0], evt.sdi};
    assign op_done = shift_in && (bitcnt_q == 6'(sfe_pkg::OP_W - 1));
    assign addr_done = shift_in && (bitcnt_q == 6'(sfe_pkg::OP_W * (1 + sfe_pkg::ADDR_BYTES) - 1));
    assign addr_now = {shreg_q[22:0], evt.sdi};
    assign is_write = writes_array(opcode_q);
    assign is_prot = (opcode_q == sfe_pkg::OPC_PROT_WRITE);
    // The page field moves up one bit with the longer page, so the sector index follows.
    assign sector_idx = page_alt_q ? addr_now[20:17] : addr_now[19:16];
    assign guarded = (guard_on || armed_q) && prot_q[sector_idx[2:0]];
    assign tmr_start = addr_done && is_write && !guarded;

    always_comb begin
        state_d = state_q;
        case (state_q)
            sfe_pkg::ST_IDLE: begin
                if (evt.frame_start && por_done) begin
                    state_d = sfe_pkg::ST_CMD;
                end
            end
            sfe_pkg::ST_CMD: begin
                if (evt.frame_end) begin
                    state_d = sfe_pkg::ST_IDLE;
                end else if (addr_done && is_write) begin
                    state_d = guarded ? sfe_pkg::ST_DROP : sfe_pkg::ST_BUSY;
                end
            end
            sfe_pkg::ST_DROP: begin
                if (evt.frame_end) begin
                    state_d = sfe_pkg::ST_IDLE;
                end
            end
            sfe_pkg::ST_BUSY: begin
                if (!busy && !evt.selected) begin
                    state_d = sfe_pkg::ST_IDLE;
                end
            end
            default: state_d = sfe_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= sfe_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bit counter and shift register clear at every frame start.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            shreg_q <= 32'h00000000;
            bitcnt_q <= 6'h00;
        end else if (evt.frame_start) begin
            shreg_q <= 32'h00000000;
            bitcnt_q <= 6'h00;
        end else if (shift_in) begin
            shreg_q <= {shreg_q[30:0], evt.sdi};
            bitcnt_q <= (bitcnt_q == 6'h3F) ? bitcnt_q : bitcnt_q + 6'h01;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            cmd_valid_q <= 1'b0;
        end else begin
            cmd_valid_q <= addr_done && !(is_write && guarded);
            if (op_done) begin
                opcode_q <= op_now;
            end
            if (addr_done) begin
                addr_q <= addr_now;
            end
        end
    end

    // Lock map, software arming and page length, all altered at frame end.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            prot_q <= sfe_pkg::PROT_MAP_RESET;
            armed_q <= 1'b0;
            page_alt_q <= 1'b0;
        end else if (evt.frame_end && state_q == sfe_pkg::ST_CMD) begin
            if (is_prot && !guard_on && bitcnt_q == 6'h28) begin
                prot_q <= shreg_q[7:0];
            end
            if (opcode_q == sfe_pkg::OPC_PROT_ARM && bitcnt_q == 6'h20) begin
                armed_q <= 1'b1;
            end
            if (opcode_q == sfe_pkg::OPC_PAGE_SIZE && bitcnt_q == 6'h20) begin
                page_alt_q <= shreg_q[0];
            end
        end
    end

    // Output shifter: loads status after the opcode and moves on falling edges.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            out_q <= 8'h00;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (!evt.selected) begin
            oe_q <= 1'b0;
            sdo_q <= 1'b0;
        end else if (evt.fall && bitcnt_q >= 6'(sfe_pkg::OP_W) &&
                opcode_q == sfe_pkg::OPC_STATUS_READ) begin
            // A fresh status snapshot is reloaded from STATUS_IN once the eight bits are gone.
            oe_q <= 1'b1;
            sdo_q <= (bitcnt_q[2:0] == 3'h0) ? busy : out_q[7];
            out_q <= (bitcnt_q[2:0] == 3'h0) ? {STATUS_IN[6:0], 1'b0} : {out_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            standby_q <= 1'b1;
        end else begin
            standby_q <= !evt.selected && (state_d == sfe_pkg::ST_IDLE);
        end
    end

    // The busy pin is registered so it never shows a decode glitch.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d == sfe_pkg::ST_BUSY);
        end
    end

    assign SDO = sdo_q;
    assign SDO_OE = oe_q;
    assign STANDBY = standby_q;
    assign BUSY = busy_q;
    assign PAGE_ALT = page_alt_q;
    assign OPCODE = opcode_q;
    assign ADDRESS = addr_q;
    assign CMD_VALID = cmd_valid_q;
    assign PROT_MAP = prot_q;

    // Checks look at synchronised and registered state only, never at raw pins.
    a_deselect_hiz: assert property (@(posedge CLK) disable iff (!NRST)
        !evt.selected |=> !SDO_OE)
        else $error("Output driven while deselected.");
    a_deselect_standby: assert property (@(posedge CLK) disable iff (!NRST)
        (!evt.selected && state_q == sfe_pkg::ST_IDLE) |=> STANDBY)
        else $error("Idle and deselected without standby.");
    a_no_shift_idle: assert property (@(posedge CLK) disable iff (!NRST)
        (!evt.selected && !evt.frame_start) |=> $stable(bitcnt_q))
        else $error("Bits shifted while deselected.");
    a_frame_idle: assert property (@(posedge CLK) disable iff (!NRST)
        (evt.frame_end && state_q == sfe_pkg::ST_CMD) |=> state_q == sfe_pkg::ST_IDLE)
        else $error("Frame end did not return to idle.");
    a_fresh_frame: assert property (@(posedge CLK) disable iff (!NRST)
        $rose(state_q == sfe_pkg::ST_CMD) |-> $past(evt.frame_start) && $past(por_done))
        else $error("Command phase entered without a fresh frame start.");
    a_frame_clear: assert property (@(posedge CLK) disable iff (!NRST)
        evt.frame_start |=> bitcnt_q == 6'h00)
        else $error("Partial bits kept at frame start.");

    a_shift_msb: assert property (@(posedge CLK) disable iff (!NRST)
        shift_in |=> shreg_q[0] == $past(evt.sdi))
        else $error("Input bit not taken on the clock rise.");
    a_sdo_on_fall: assert property (@(posedge CLK) disable iff (!NRST)
        (SDO_OE && $changed(SDO)) |-> $past(evt.fall))
        else $error("Output bit moved away from a clock fall.");
    a_guard_lock: assert property (@(posedge CLK) disable iff (!NRST)
        guard_on |=> prot_q == $past(prot_q))
        else $error("Lock map changed under guard.");
    a_guard_drop: assert property (@(posedge CLK) disable iff (!NRST)
        (addr_done && is_write && guarded) |=> state_q == sfe_pkg::ST_DROP && !busy)
        else $error("Guarded command was not dropped.");

    // Taking a write and then running the internal timer are two steps of one operation.
    sequence s_write_accept;
        addr_done && is_write && !guarded;
    endsequence
    sequence s_timed_run;
        (state_q == sfe_pkg::ST_BUSY && busy) [*2];
    endsequence
    a_write_timed: assert property (@(posedge CLK) disable iff (!NRST)
        s_write_accept |=> s_timed_run)
        else $error("Accepted write did not run its timer.");
    a_busy_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (state_q == sfe_pkg::ST_BUSY && busy) |=> state_q == sfe_pkg::ST_BUSY)
        else $error("Left busy before internal completion.");
    a_start_busy: assert property (@(posedge CLK) disable iff (!NRST)
        tmr_start |=> busy [*3])
        else $error("Internal timer did not start.");
endmodule

/* sfe_host.sv */
// Host serial master model that frames commands and collects read bits.
`timescale 1ns/100ps
module sfe_host (
    input wire logic CLK,
    input wire logic SDO,
    input wire logic SDO_OE,
    output logic SEL_N,
    output logic SCK,
    output logic SDI
);
    logic mode3 = 1'b0;
    logic [63:0] rx = 64'h0;
    initial begin
        SEL_N = 1'b1;
        SCK = 1'b0;
        SDI = 1'b0;
    end
    // Lets a scenario hold or release select across a reset without a full frame.
    task automatic sel(input logic v);
        SEL_N = v;
    endtask
    task automatic half();
        repeat (8) @(negedge CLK);
    endtask
    // Shifts the low n bits of d; hold leaves the select line to the caller.
    task automatic xfer(input logic [63:0] d, input int n, input bit hold);
        SCK = mode3;
        half();
        if (!hold) SEL_N = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            SCK = 1'b0;
            SDI = d[i];
            half();
            SCK = 1'b1;
            // An undriven output reads inverted, so a missing enable shows up.
            rx = {rx[62:0], SDO_OE ? SDO : ~SDO};
            half();
        end
        SCK = mode3;
        half();
        if (!hold) SEL_N = 1'b1;
    endtask
endmodule

/* testbench.sv */
// Self-checking testbench for the serial flash pin front end.
`timescale 1ns/100ps
module testbench;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic WGUARD_N = 1'b1;
    logic [7:0] STATUS_IN = 8'h5A;
    logic SEL_N, SCK, SDI, SDO, SDO_OE, STANDBY, BUSY, PAGE_ALT, CMD_VALID;
    logic [7:0] OPCODE;
    logic [7:0] PROT_MAP;
    logic [23:0] ADDRESS;
    int n_errors = 0;
    int compares = 0;
    int n_cv = 0;
    initial forever #5 CLK = ~CLK;
    // Counted on the falling edge, away from the edge that launches the pulse.
    always @(negedge CLK) begin
        if (CMD_VALID === 1'b1) n_cv++;
    end
    // A short busy time keeps the run brief but outlasts the checks made as a frame closes.
    sfe_front_end #(.BUSY_CYCLES(60)) u_sfe_front_end (.CLK(CLK), .NRST(NRST),
        .SEL_N(SEL_N), .SCK(SCK), .SDI(SDI), .WGUARD_N(WGUARD_N), .STATUS_IN(STATUS_IN),
        .SDO(SDO), .SDO_OE(SDO_OE), .STANDBY(STANDBY), .BUSY(BUSY), .PAGE_ALT(PAGE_ALT),
        .OPCODE(OPCODE), .ADDRESS(ADDRESS), .CMD_VALID(CMD_VALID), .PROT_MAP(PROT_MAP));
    sfe_host u_sfe_host (.CLK(CLK), .SDO(SDO), .SDO_OE(SDO_OE), .SEL_N(SEL_N),
        .SCK(SCK), .SDI(SDI));
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask
    task automatic done(input string s);
        $display("test %s ended, mismatches %0d", s, n_errors);
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 200 && !(BUSY === 1'b0 && STANDBY === 1'b1); i++) cyc(1);
        if (i == 200) begin
            n_errors++;
            $display("MISMATCH t=%0t idle wait ran out", $time);
            summarize();
        end
    endtask
    task automatic frame(input logic [63:0] d, input int n);
        u_sfe_host.xfer(d, n, 1'b0);
        cyc(6);
    endtask
    task automatic op_cmd(input logic [7:0] op, input logic [23:0] a, input logic ok);
        int c;
        c = n_cv;
        frame({32'h0, op, a}, 32);
        chk(n_cv - c, {31'h0, ok}, "pulse");
        chk(BUSY, ok, "busy");
        chk(STANDBY, {31'h0, ~ok}, "standby");
        if (ok) chk({OPCODE, ADDRESS}, {op, a}, "cmd");
        wait_idle();
    endtask
    task automatic t_reset();
        chk({STANDBY, SDO_OE, BUSY, PAGE_ALT, PROT_MAP}, 12'h800, "rst");
        done("reset");
    endtask
    task automatic t_cmds();
        logic [7:0] ops [4] = '{sfe_pkg::OPC_PAGE_PROGRAM, sfe_pkg::OPC_PAGE_ERASE,
            sfe_pkg::OPC_BLOCK_ERASE, sfe_pkg::OPC_SECTOR_ERASE};
        for (int i = 0; i < 4; i++) begin
            u_sfe_host.mode3 = i[0];
            op_cmd(ops[i], 24'hC35A0F, 1'b1);
        end
        done("cmds");
    endtask
    task automatic t_desel();
        int c;
        c = n_cv;
        // Another device on a shared bus is clocked while this one is deselected.
        u_sfe_host.xfer({32'h0, sfe_pkg::OPC_PAGE_PROGRAM, 24'h0}, 32, 1'b1);
        cyc(6);
        chk(n_cv - c, 0, "desel pulse");
        chk({BUSY, OPCODE}, {1'b0, sfe_pkg::OPC_SECTOR_ERASE}, "desel op");
        done("desel");
    endtask
    task automatic t_status();
        for (int m = 0; m < 2; m++) begin
            u_sfe_host.mode3 = m[0];
            STATUS_IN = m ? 8'hA5 : 8'h5A;
            frame({48'h0, sfe_pkg::OPC_STATUS_READ, 8'h00}, 16);
            chk(u_sfe_host.rx[7:0], {1'b0, STATUS_IN[6:0]}, "status");
            chk(SDO_OE, 1'b0, "oe");
        end
        u_sfe_host.mode3 = 1'b0;
        done("status");
    endtask
    task automatic t_guard();
        frame({24'h0, sfe_pkg::OPC_PROT_WRITE, 24'h0, 8'h01}, 40);
        chk(PROT_MAP, 8'h01, "map set");
        WGUARD_N = 1'b0;
        frame({24'h0, sfe_pkg::OPC_PROT_WRITE, 24'h0, 8'hFF}, 40);
        chk(PROT_MAP, 8'h01, "map kept");
        op_cmd(sfe_pkg::OPC_SECTOR_ERASE, 24'h000000, 1'b0);
        op_cmd(sfe_pkg::OPC_PAGE_PROGRAM, 24'h010000, 1'b1);
        WGUARD_N = 1'b1;
        frame({32'h0, sfe_pkg::OPC_PROT_ARM, 24'h0}, 32);
        op_cmd(sfe_pkg::OPC_PAGE_ERASE, 24'h000000, 1'b0);
        done("guard");
    endtask
    task automatic t_page();
        for (int v = 1; v >= 0; v--) begin
            frame({32'h0, sfe_pkg::OPC_PAGE_SIZE, 23'h0, v[0]}, 32);
            chk(PAGE_ALT, v[0], "page");
            // Sector index moves up one bit with the longer page.
            op_cmd(sfe_pkg::OPC_PAGE_ERASE, 24'h010000, ~v[0]);
        end
        done("page");
    endtask
    task automatic t_abort();
        int c;
        u_sfe_host.xfer({32'h0, sfe_pkg::OPC_PAGE_PROGRAM, 24'h030000}, 32, 1'b0);
        NRST = 1'b0;
        u_sfe_host.sel(1'b0);
        cyc(2);
        chk({BUSY, STANDBY, SDO_OE}, 3'b010, "abort");
        cyc(30);
        chk({BUSY, STANDBY}, 2'b01, "held");
        NRST = 1'b1;
        cyc(10);
        c = n_cv;
        u_sfe_host.xfer({32'h0, sfe_pkg::OPC_PAGE_PROGRAM, 24'h030000}, 32, 1'b1);
        chk(n_cv - c, 0, "no fresh edge");
        u_sfe_host.sel(1'b1);
        cyc(6);
        op_cmd(sfe_pkg::OPC_PAGE_PROGRAM, 24'h030000, 1'b1);
        done("abort");
    endtask
    initial begin
        cyc(3);
        NRST = 1'b1;
        cyc(8);
        t_reset();
        t_cmds();
        t_desel();
        t_status();
        t_guard();
        t_page();
        t_abort();
        summarize();
    end
endmodule
